// file: verification/ddrio_mem_model.sv
// behavioural memory on the far side of the dq lines
module ddrio_mem_model
	import ddrio_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rd_en_in,
	input  wire logic [15:0] rd_pair_in,
	input  wire ddrio_dq_t   dq_out_in,
	input  wire ddrio_dq_t   dq_oe_n_in,
	output ddrio_dq_t        dq_line_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// eight plain data lines: any check bits are the controller's own logic
	// stands for a ddr sdram part, so no qdr ii burst-of-two traffic arises
	ddrio_dq_t drv = 8'h5A;
	// with rd_en_in low, released lines flip every half so stale data never looks like a capture
	always @(clk_in) begin
		#2;
		drv = rd_en_in ? (clk_in ? rd_pair_in[7:0] : rd_pair_in[15:8]) : ~drv;
	end
	// board delay: the capture flops must not race the clock-selected pin mux
	assign #1 dq_line_out = (dq_oe_n_in & drv) | (~dq_oe_n_in & dq_out_in);
endmodule // ddrio_mem_model

// file: verification/ddrio_top_checker.sv
// port assertions for the double-rate io path
module ddrio_top_checker (
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        wr_valid_in,
	input wire logic        drain_hold_in,
	input wire logic [12:0] addr_in,
	input wire logic [2:0]  cmd_in,
	input wire logic [12:0] addr_out,
	input wire logic [2:0]  cmd_out,
	input wire logic [7:0]  dq_in,
	input wire logic [7:0]  dq_oe_n_out,
	input wire logic        dqs_out,
	input wire logic        dqs_oe_n_out,
	input wire logic        mem_clk_p_out,
	input wire logic        mem_clk_n_out,
	input wire logic [7:0]  rd_lo_out,
	input wire logic [7:0]  rd_hi_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0]  up_reg;
	logic        hi_oe_n_reg;
	logic [7:0]  fall_dq_reg;
	logic [15:0] fall_ac_reg;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// output pipeline needs a few edges after release before the pins mean anything
	always_ff @(posedge clk_in or negedge rstn_in)
		up_reg <= !rstn_in ? 2'h0 : up_reg + {1'b0, up_reg != 2'h3};
	// falling-edge samples give the high-phase view of the pins
	always_ff @(negedge clk_in) begin
		hi_oe_n_reg <= $sampled(dqs_oe_n_out);
		fall_dq_reg <= $sampled(dq_in);
		fall_ac_reg <= $sampled({cmd_out, addr_out});
	end
	////////////////////////////////////////
	property p_ac_reg; up_reg == 2'h3 |-> {cmd_out, addr_out} == $past({cmd_in, addr_in}); endproperty
	a_ac_reg: assert property (p_ac_reg) else $error("addr/cmd not registered");
	property p_ac_sdr; up_reg == 2'h3 |-> {cmd_out, addr_out} == fall_ac_reg; endproperty
	a_ac_sdr: assert property (p_ac_sdr) else $error("addr/cmd moved at falling edge");
	property p_clk_lo; up_reg == 2'h3 |-> !mem_clk_p_out && mem_clk_n_out; endproperty
	a_clk_lo: assert property (p_clk_lo) else $error("memory clock wrong in low phase");
	property p_clk_hi; @(negedge clk_in) up_reg == 2'h3 |-> mem_clk_p_out && !mem_clk_n_out; endproperty
	a_clk_hi: assert property (p_clk_hi) else $error("memory clock wrong in high phase");
	property p_dqs_lo; !dqs_oe_n_out |-> !dqs_out; endproperty
	a_dqs_lo: assert property (p_dqs_lo) else $error("strobe high in low phase");
	property p_dqs_hi; @(negedge clk_in) !dqs_oe_n_out |-> dqs_out; endproperty
	a_dqs_hi: assert property (p_dqs_hi) else $error("strobe low in high phase");
	property p_preamble; !dqs_oe_n_out |-> !hi_oe_n_reg; endproperty
	a_preamble: assert property (p_preamble) else $error("strobe enabled without preamble");
	property p_oe_form; @(negedge clk_in) dq_oe_n_out == {8{dqs_oe_n_out}}; endproperty
	a_oe_form: assert property (p_oe_form) else $error("data and strobe enables differ");
	property p_rd_hi; up_reg == 2'h3 |-> rd_hi_out == $past(dq_in); endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("rising capture wrong");
	property p_rd_lo; up_reg == 2'h3 |-> rd_lo_out == $past(fall_dq_reg); endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("falling capture wrong");
	property p_idle; (!wr_valid_in && !drain_hold_in) [*7] |-> dqs_oe_n_out && (&dq_oe_n_out); endproperty
	a_idle: assert property (p_idle) else $error("pins driven while idle");
	c_burst: cover property (!dqs_oe_n_out [*3]);
	c_start: cover property ($fell(dqs_oe_n_out));
	c_read: cover property (rd_hi_out != rd_lo_out);
endmodule // ddrio_top_checker

bind ddrio_top ddrio_top_checker chk_i (.clk_in, .rstn_in, .wr_valid_in, .drain_hold_in, .addr_in, .cmd_in,
	.addr_out, .cmd_out, .dq_in, .dq_oe_n_out, .dqs_out, .dqs_oe_n_out, .mem_clk_p_out, .mem_clk_n_out,
	.rd_lo_out, .rd_hi_out);

// file: verification/ddrio_top_tb.sv
// random and corner-case bench for the double-rate io path
module ddrio_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ddrio_pkg::*;
	logic        clk_in = 1'b0, rstn_in = 1'b0, wr_oe_in = 1'b0, wr_valid_in = 1'b0, drain_hold_in = 1'b0;
	logic        wr_ready_out, dqs_out, dqs_oe_n_out, mem_clk_p_out, mem_clk_n_out, rdy_pre;
	logic        rd_en = 1'b0, chk_on = 1'b0, took = 1'b0;
	ddrio_dq_t   wr_lo_in = 8'h00, wr_hi_in = 8'h00, dq_in, dq_out, dq_oe_n_out, rd_lo_out, rd_hi_out;
	ddrio_dq_t   fall_pre, rise_pre, rh_exp, rl_exp;
	ddrio_addr_t addr_in = 13'h0000, addr_out;
	ddrio_cmd_t  cmd_in = 3'h0, cmd_out;
	logic [15:0] rd_pair = 16'h0000, ac_exp;
	logic [31:0] seed = 32'h501E, r, s;
	ddrio_word_t q[$], cur = 17'h00000, prev = 17'h00000;
	int          fail_count = 0, n_tests = 0, cyc = 0;

	always #5 clk_in = ~clk_in;
	ddrio_top dut (.clk_in, .rstn_in, .wr_lo_in, .wr_hi_in, .wr_oe_in, .wr_valid_in, .wr_ready_out,
		.drain_hold_in, .addr_in, .cmd_in, .addr_out, .cmd_out, .dq_in, .dq_out, .dq_oe_n_out, .dqs_out,
		.dqs_oe_n_out, .mem_clk_p_out, .mem_clk_n_out, .rd_lo_out, .rd_hi_out);
	ddrio_mem_model mem (.clk_in, .rd_en_in(rd_en), .rd_pair_in(rd_pair), .dq_out_in(dq_out),
		.dq_oe_n_in(dq_oe_n_out), .dq_line_out(dq_in));
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic lo_oe_n(input ddrio_word_t c, input ddrio_word_t p);
		return !(c[16] && p[16]);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// a refused word stays offered until the fifo takes it
	task automatic offer(input logic v, input logic oe);
		@(negedge clk_in);
		if (!wr_valid_in || took) begin
			s = rnd();
			wr_valid_in = v;
			wr_oe_in = oe;
			wr_lo_in = s[7:0];
			wr_hi_in = s[15:8];
		end
	endtask
	////////////////////////////////////////
	// sample just ahead of each edge, where pins and model are settled
	always @(clk_in) begin
		#4.9;
		if (clk_in)
			fall_pre = dq_in;
		else
			rise_pre = dq_in;
		rdy_pre = wr_ready_out;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 1000) begin
			fail_count++;
			tally_and_finish();
		end
		prev = cur;
		cur = (q.size() > 0 && !drain_hold_in) ? q.pop_front() : 17'h00000;
		took = wr_valid_in && rdy_pre;
		if (took)
			q.push_back({wr_oe_in, wr_hi_in, wr_lo_in});
		ac_exp = {cmd_in, addr_in};
		rl_exp = fall_pre;
		rh_exp = rise_pre;
		#3;
		if (chk_on) begin
			chk(dqs_oe_n_out, !prev[16]);
			chk({cmd_out, addr_out}, ac_exp);
			chk(rd_hi_out, rh_exp);
			chk(rd_lo_out, rl_exp);
			if (prev[16]) begin
				chk(dq_out, prev[15:8]);
				chk(dqs_out, 1'b1);
				chk(dq_oe_n_out, 8'h00);
			end
		end
	end
	always @(negedge clk_in) begin
		#3;
		if (chk_on) begin
			chk(dqs_oe_n_out, lo_oe_n(cur, prev));
			if (cur[16])
				chk(dq_out, cur[7:0]);
			if (!lo_oe_n(cur, prev))
				chk(dqs_out, 1'b0);
		end
	end
	////////////////////////////////////////
	initial begin
		@(negedge clk_in);
		chk(wr_ready_out, 1'b1);
		chk(dqs_oe_n_out, 1'b1);
		chk(mem_clk_n_out, 1'b1);
		chk(mem_clk_p_out, 1'b0);
		@(negedge clk_in);
		rstn_in = 1'b1;
		repeat (3) @(posedge clk_in);
		chk_on = 1'b1;
		// random traffic, ending with a held drain that fills the fifo
		for (int i = 0; i < 300; i++) begin
			r = rnd();
			offer(r[0] | r[1] | (i > 280), r[2] | r[3]);
			drain_hold_in = (i > 280) | (r[4] & r[5]);
			{cmd_in, addr_in} = r[31:16];
			rd_en = r[6];
			rd_pair = r[23:8];
		end
		chk(wr_ready_out, 1'b0);
		chk(q.size(), 16'h0004);
		drain_hold_in = 1'b0;
		repeat (8) offer(1'b0, 1'b0);
		// enable pattern: first word after a gap needs the preamble
		for (int i = 0; i < 6; i++)
			offer(1'b1, i % 3 != 0);
		repeat (10) offer(1'b0, 1'b0);
		tally_and_finish();
	end
endmodule // ddrio_top_tb

// file: verilog/ddrio_defs.svh
// widths, field positions, reset values and depths of the double-rate io path
`ifndef DDRIO_DEFS_SVH
`define DDRIO_DEFS_SVH

`define DDRIO_DQ_W        8
`define DDRIO_ADDR_W      13
`define DDRIO_CMD_W       3
`define DDRIO_ECC_DATA_W  64
`define DDRIO_ECC_CHECK_W 8
`define DDRIO_WORD_W      17
`define DDRIO_LO_LSB      0
`define DDRIO_HI_LSB      8
`define DDRIO_OE_BIT      16
`define DDRIO_FIFO_DEPTH  4
`define DDRIO_CLK_MHZ     100
`define DDRIO_CLK_PER_NS  10
`define DDRIO_OE_N_RST    1'b1
`define DDRIO_STROBE_LO   1'b0
`define DDRIO_STROBE_HI   1'b1

`endif

// file: verilog/ddrio_fifo.sv
// small synchronous fifo with valid/ready on both sides
module ddrio_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input  wire logic  clk_in,
	input  wire logic  rstn_in,
	ddrio_stream_if.snk wr,
	ddrio_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wptr_reg;
	logic [AW:0]      wptr_next;
	logic [AW:0]      rptr_reg;
	logic [AW:0]      rptr_next;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	//////////////////////////////////////////////////////////////////////
	// extra pointer bit tells full from empty
	assign empty    = (wptr_reg == rptr_reg);
	assign full     = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem_reg[rptr_reg[AW-1:0]];
	assign push     = wr.valid && !full;
	assign pop      = rd.ready && !empty;

	always_comb begin
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		if (push) begin
			wptr_next = wptr_reg + 1'b1;
		end
		if (pop) begin
			rptr_next = rptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
		end
	end

	// storage needs no reset: nothing reads an entry before it is written
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_reg[wptr_reg[AW-1:0]] <= wr.data;
		end
	end
endmodule // ddrio_fifo

// file: verilog/ddrio_out_cell.sv
// one double-rate output cell: two load registers, dual-edge retime, clock mux
module ddrio_out_cell #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] lo_in,
	input  wire logic [W-1:0] hi_in,
	input  wire logic [W-1:0] rst_val_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] first_output_register;
	logic [W-1:0] second_output_register;
	logic [W-1:0] first_fall_reg;
	logic [W-1:0] second_rise_reg;
	logic [W-1:0] first_next;
	logic [W-1:0] second_next;

	// registers hold data xor rst_val_in, so a zero reset shows the reset value
	always_comb begin
		first_next  = lo_in ^ rst_val_in; // RQ2
		second_next = hi_in ^ rst_val_in; // RQ2
	end

	// keeps enables inactive from release until the first word is loaded
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			first_output_register  <= '0;
			second_output_register <= '0;
			second_rise_reg        <= '0;
		end else begin
			first_output_register  <= first_next;
			second_output_register <= second_next;
			second_rise_reg        <= second_output_register; // RQ4
		end
	end

	always_ff @(negedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			first_fall_reg <= '0;
		end else begin
			first_fall_reg <= first_output_register; // RQ3
		end
	end

	// low phase shows the first half, high phase the second half
	always_comb begin
		pin_out = (clk_in ? second_rise_reg : first_fall_reg) ^ rst_val_in; // RQ5
		if (!rstn_in) begin
			pin_out = rst_val_in;
		end
	end
endmodule // ddrio_out_cell

// file: verilog/ddrio_pkg.sv
// types shared by the double-rate io path
package ddrio_pkg;
`include "ddrio_defs.svh"

	typedef logic [`DDRIO_DQ_W-1:0]   ddrio_dq_t;
	typedef logic [`DDRIO_ADDR_W-1:0] ddrio_addr_t;
	typedef logic [`DDRIO_CMD_W-1:0]  ddrio_cmd_t;
	typedef logic [`DDRIO_WORD_W-1:0] ddrio_word_t;

endpackage : ddrio_pkg

// file: verilog/ddrio_stream_if.sv
// valid/ready word carrier between the path's own modules
interface ddrio_stream_if #(
	parameter int WIDTH = 1
);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : ddrio_stream_if

// file: verilog/ddrio_top.sv
// double-rate io register path toward an external ddr sdram or qdr ii sram
//
// Summary of operation
// RQ1: every dq input is captured by three flip-flops next to the pin.
// RQ2: low and high streams load both output registers on one edge.
// RQ3: the first output register is retimed on the falling clock edge.
// RQ4: the second output register is retimed on the rising clock edge.
// RQ5: the clock itself selects between the two retimed values, two bits per period.
// RQ6: output enables use the same two-register dual-edge structure as data.
// RQ7: active-low enable holds high impedance an extra half cycle for preamble.
// RQ8: memory clock pair is made through the double-rate output registers.
// RQ9: address and command outputs change at most once per clock period.
// RQ10: controllers using 72-bit ecc words generate and check ecc themselves.
// RQ11: controllers must not run qdr ii sram at burst length two.
// RQ12: while enable is inactive the pin stays high impedance regardless of data.
module ddrio_top
	import ddrio_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic [7:0]  wr_lo_in,
	input  wire logic [7:0]  wr_hi_in,
	input  wire logic        wr_oe_in,
	input  wire logic        wr_valid_in,
	output logic             wr_ready_out,
	input  wire logic        drain_hold_in,
	input  wire logic [12:0] addr_in,
	input  wire logic [2:0]  cmd_in,
	output logic      [12:0] addr_out,
	output logic      [2:0]  cmd_out,
	input  wire logic [7:0]  dq_in,
	output logic      [7:0]  dq_out,
	output logic      [7:0]  dq_oe_n_out,
	output logic             dqs_out,
	output logic             dqs_oe_n_out,
	output logic             mem_clk_p_out,
	output logic             mem_clk_n_out,
	output logic      [7:0]  rd_lo_out,
	output logic      [7:0]  rd_hi_out
);
	localparam int OE_W = `DDRIO_DQ_W + 1;

	ddrio_stream_if #(.WIDTH(`DDRIO_WORD_W)) wr_if ();
	ddrio_stream_if #(.WIDTH(`DDRIO_WORD_W)) rd_if ();

	ddrio_word_t word;
	logic        pop;
	logic        oe_n_now;
	logic        oe_n_prev_reg;
	logic        oe_n_prev_next;
	ddrio_dq_t   dat_lo;
	ddrio_dq_t   dat_hi;
	logic        strb_lo;
	logic        strb_hi;
	logic [OE_W-1:0] oe_lo_n;
	logic [OE_W-1:0] oe_hi_n;
	logic [OE_W-1:0] oe_pin_n;
	ddrio_addr_t addr_reg;
	ddrio_addr_t addr_next;
	ddrio_cmd_t  cmd_reg;
	ddrio_cmd_t  cmd_next;
	ddrio_dq_t   cap_rise_reg;
	ddrio_dq_t   cap_rise_next;
	ddrio_dq_t   cap_fall_reg;
	ddrio_dq_t   cap_fall_next;
	ddrio_dq_t   cap_fall_sync_reg;
	ddrio_dq_t   cap_fall_sync_next;
	logic [1:0]  mclk_pin;

	//////////////////////////////////////////////////////////////////////
	// write words wait in a 4-entry fifo; drain_hold_in stalls the drain
	assign wr_if.data   = {wr_oe_in, wr_hi_in, wr_lo_in};
	assign wr_if.valid  = wr_valid_in;
	assign wr_ready_out = wr_if.ready;

	ddrio_fifo #(
		.WIDTH(`DDRIO_WORD_W),
		.DEPTH(`DDRIO_FIFO_DEPTH)
	) u_fifo (
		.clk_in (clk_in),
		.rstn_in(rstn_in),
		.wr     (wr_if),
		.rd     (rd_if)
	);

	assign rd_if.ready = !drain_hold_in;
	assign pop         = rd_if.valid && !drain_hold_in;
	assign word        = rd_if.data;

	//////////////////////////////////////////////////////////////////////
	// one popped word feeds one clock period on the pins
	always_comb begin
		oe_n_now       = !(pop && word[`DDRIO_OE_BIT]);
		dat_lo         = pop ? word[`DDRIO_LO_LSB +: `DDRIO_DQ_W] : '0;
		dat_hi         = pop ? word[`DDRIO_HI_LSB +: `DDRIO_DQ_W] : '0;
		strb_lo        = `DDRIO_STROBE_LO;
		strb_hi        = oe_n_now ? `DDRIO_STROBE_LO : `DDRIO_STROBE_HI;
		oe_n_prev_next = oe_n_now;
		// first driven word keeps its low half tristated: strobe preamble
		oe_lo_n = {OE_W{oe_n_now | oe_n_prev_reg}}; // RQ7
		oe_hi_n = {OE_W{oe_n_now}};
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			oe_n_prev_reg <= `DDRIO_OE_N_RST;
		end else begin
			oe_n_prev_reg <= oe_n_prev_next;
		end
	end

	ddrio_out_cell #(.W(`DDRIO_DQ_W + 1)) u_data_cell (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.lo_in     ({strb_lo, dat_lo}),
		.hi_in     ({strb_hi, dat_hi}),
		.rst_val_in('0),
		.pin_out   ({dqs_out, dq_out})
	);

	ddrio_out_cell #(.W(OE_W)) u_oe_cell ( // RQ6
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.lo_in     (oe_lo_n),
		.hi_in     (oe_hi_n),
		.rst_val_in({OE_W{`DDRIO_OE_N_RST}}),
		.pin_out   (oe_pin_n)
	);

	// data registers never override the enable path
	assign dq_oe_n_out  = oe_pin_n[`DDRIO_DQ_W-1:0]; // RQ12
	assign dqs_oe_n_out = oe_pin_n[`DDRIO_DQ_W]; // RQ12

	//////////////////////////////////////////////////////////////////////
	// memory clock pair: constant halves so it matches the strobe's form
	ddrio_out_cell #(.W(2)) u_mclk_cell ( // RQ8
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.lo_in     (2'h2),
		.hi_in     (2'h1),
		.rst_val_in(2'h2),
		.pin_out   (mclk_pin)
	);

	assign mem_clk_p_out = mclk_pin[0];
	assign mem_clk_n_out = mclk_pin[1];

	//////////////////////////////////////////////////////////////////////
	// address and command: single rate, rising edge only
	always_comb begin
		addr_next = addr_in; // RQ9
		cmd_next  = cmd_in; // RQ9
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_reg <= '0;
			cmd_reg  <= '0;
		end else begin
			addr_reg <= addr_next;
			cmd_reg  <= cmd_next;
		end
	end

	assign addr_out = addr_reg;
	assign cmd_out  = cmd_reg;

	//////////////////////////////////////////////////////////////////////
	// read capture: rise, fall, and fall retimed to the rising edge
	always_comb begin
		cap_rise_next      = dq_in; // RQ1
		cap_fall_next      = dq_in; // RQ1
		cap_fall_sync_next = cap_fall_reg; // RQ1
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cap_rise_reg      <= '0;
			cap_fall_sync_reg <= '0;
		end else begin
			cap_rise_reg      <= cap_rise_next;
			cap_fall_sync_reg <= cap_fall_sync_next;
		end
	end

	always_ff @(negedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cap_fall_reg <= '0;
		end else begin
			cap_fall_reg <= cap_fall_next;
		end
	end

	assign rd_hi_out = cap_rise_reg;
	assign rd_lo_out = cap_fall_sync_reg;
endmodule // ddrio_top
